/* File: counter_assertions.sv */
module counter_checks
  import counter_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // counter pins
  input wire logic        async_zero_n,
  input wire logic        cascade_gate_in,
  input wire logic        count_bit0,
  input wire logic        count_bit1,
  input wire logic        count_bit2,
  input wire logic        count_bit3,
  input wire logic        terminal_carry_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic       acc;
  logic       rd_stat;
  // count word and access phase decodes
  assign cnt = {count_bit3, count_bit2, count_bit1, count_bit0};
  assign acc = psel && penable;
  assign rd_stat = acc && !pwrite && paddr == ADDR_STATUS;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  carry_needs_max_a: assert property (
    terminal_carry_out |-> cnt == COUNT_MAX) else $error("carry off max");
  clear_zeroes_a: assert property (
    !async_zero_n |-> cnt == COUNT_RESET && !terminal_carry_out)
    else $error("clear left count");
  status_count_a: assert property (
    rd_stat |-> prdata[3:0] == $past(cnt)) else $error("status count");
  status_carry_a: assert property (
    rd_stat |-> prdata[4] == (prdata[6] && prdata[3:0] == COUNT_MAX))
    else $error("status carry");
  status_hold_a: assert property (
    rd_stat && !prdata[6] |-> prdata[9:8] != MODE_COUNT)
    else $error("count without cascade");
  err_unmapped_a: assert property (
    acc && paddr > ADDR_WRAPS |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access");
  err_status_wr_a: assert property (
    acc && pwrite && paddr == ADDR_STATUS |-> pslverr)
    else $error("status write accepted");
  err_access_only_a: assert property (
    pslverr |-> acc && pready) else $error("error outside access");
endmodule // counter_checks

bind sync_4bit_binary_counter counter_checks counter_checks_inst (.*);

/* File: counter_pkg.sv */
package counter_pkg;

  // --------------------------------------------------------------------
  // counter geometry and reset values
  // --------------------------------------------------------------------
  localparam int         COUNT_WIDTH  = 4;
  localparam logic [3:0] COUNT_RESET  = 4'h0;
  localparam logic [3:0] COUNT_MAX    = 4'hf;
  localparam logic [3:0] PRESET_RESET = 4'h0;
  localparam int         WRAP_WIDTH   = 16;

  // --------------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PRESET = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0c;
  localparam logic [7:0] ADDR_WRAPS  = 8'h10;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int CTRL_PERMIT_BIT   = 0;
  localparam int CTRL_CASCADE_BIT  = 1;
  localparam int CTRL_PRESET_N_BIT = 2;
  localparam int CTRL_SRC_BIT      = 3;
  localparam int CMD_PRESET_BIT    = 0;
  localparam int CMD_STEP_BIT      = 1;
  localparam int STAT_COUNT_LSB    = 0;
  localparam int STAT_CARRY_BIT    = 4;
  localparam int STAT_ZERO_N_BIT   = 5;
  localparam int STAT_CASCADE_BIT  = 6;
  localparam int STAT_MODE_LSB     = 8;

  // control register, bit 3 down to bit 0
  typedef struct packed {
    logic cascade_src;
    logic preset_n;
    logic cascade_gate;
    logic count_permit;
  } ctrl_s;

  // enables off, preset strobe idle, cascade from register
  localparam ctrl_s CTRL_RESET = '{cascade_src:  1'b0,
                                   preset_n:     1'b1,
                                   cascade_gate: 1'b0,
                                   count_permit: 1'b0};

  // operation chosen at the next edge
  typedef enum logic [1:0] {
    MODE_HOLD   = 2'b00,
    MODE_COUNT  = 2'b01,
    MODE_PRESET = 2'b10
  } mode_e;

  // preset beats counting, counting needs both enables
  function automatic mode_e decode_mode(input logic preset_n,
                                        input logic permit,
                                        input logic cascade);
    if (!preset_n) begin
      return MODE_PRESET;
    end else if (permit && cascade) begin
      return MODE_COUNT;
    end
    return MODE_HOLD;
  endfunction

  // all-ones decode of the count
  function automatic logic at_terminal(input logic [3:0] count);
    return count == COUNT_MAX;
  endfunction

endpackage // counter_pkg

/* File: counter_stage.sv */
// ----------------------------------------------------------------------
// one presettable binary counter stage
// ----------------------------------------------------------------------
module counter_stage #(
  parameter int WIDTH = counter_pkg::COUNT_WIDTH
) (
  // clock and resets
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      async_zero_n,
  // operation levels
  input  wire counter_pkg::mode_e        mode,
  input  wire logic                      cascade_gate,
  input  wire logic [WIDTH-1:0]          preset_value,
  // results
  output logic      [WIDTH-1:0]          count,
  output logic                           terminal_carry_out
);
  import counter_pkg::*;

  logic [WIDTH-1:0] next_count;

  // next value from the mode sampled at the edge
  always_comb begin
    case (mode)
      MODE_PRESET: next_count = preset_value;
      MODE_COUNT:  next_count = WIDTH'(count + 1'b1);
      default:     next_count = count;
    endcase
  end

  // all bits on one rising edge, clear acts without the clock
  always_ff @(posedge pclk or negedge presetn or negedge async_zero_n) begin
    if (!presetn || !async_zero_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // carry decode, combinational so it may spike
  assign terminal_carry_out = cascade_gate && (&count);

endmodule // counter_stage

/* File: lower_stage_model.sv */
// ----------------------------------------------------------------------
// lower counter stage feeding the cascade pin
// ----------------------------------------------------------------------
module lower_stage_model (
  // clock and enable
  input  wire logic pclk,
  input  wire logic run,
  // carry towards the upper stage
  output logic      carry
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  // counts every edge while running
  always @(posedge pclk) begin
    if (run) begin
      cnt <= cnt + 4'h1;
    end
  end
  // carry feeds the next stage up, gated by own enable
  assign carry = run && cnt == 4'hf;
endmodule // lower_stage_model

/* File: sync_4bit_binary_counter.sv */
// ----------------------------------------------------------------------
// synchronous 4-bit counter with apb control
// ----------------------------------------------------------------------
//
// Chosen here: register access over APB and the register offsets.
module sync_4bit_binary_counter #(
  parameter int WRAPS_W = counter_pkg::WRAP_WIDTH
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // counter pins
  input  wire logic        async_zero_n,
  input  wire logic        cascade_gate_in,
  output logic             count_bit0,
  output logic             count_bit1,
  output logic             count_bit2,
  output logic             count_bit3,
  output logic             terminal_carry_out
);
  import counter_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  ctrl_s              ctrl;
  logic               sw_permit;
  logic               sw_cascade;
  logic               sw_preset_n;
  logic               sw_src;
  logic [3:0]         preset_value;
  logic               preset_pulse;
  logic               step_pulse;
  logic [WRAPS_W-1:0] wraps;
  logic [3:0]         count;
  logic               cascade_gate;
  logic               count_permit;
  logic               preset_n;
  mode_e              mode;
  logic               setup_phase;
  logic               access_phase;
  logic               wr_access;
  logic               addr_ok;
  logic               addr_ro;
  logic [31:0]        next_prdata;
  logic               ctrl_wr;
  logic               preset_wr;
  logic               cmd_wr;
  logic               wraps_wr;
  logic               rd_setup;
  logic               addr_err;
  logic               ro_err;
  logic               wrap_event;
  logic [31:0]        status_word;

  // ----------------------------------------------------------------------
  // apb phase decode
  // ----------------------------------------------------------------------

  // setup and access phases of a transfer
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access    = access_phase && pwrite && !pslverr;
  assign rd_setup     = setup_phase && !pwrite;

  // known offsets, and those that refuse writes
  always_comb begin
    addr_ok = 1'b1;
    addr_ro = 1'b0;
    if (paddr == ADDR_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_PRESET) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_STATUS) begin
      addr_ro = 1'b1;
    end else if (paddr == ADDR_CMD) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_WRAPS) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // unmapped offsets and status writes are refused
  assign addr_err = !addr_ok;
  assign ro_err   = pwrite && addr_ro;

  // zero wait states, error only in the access phase
  assign pready  = 1'b1;
  assign pslverr = access_phase && (addr_err || ro_err);

  // ----------------------------------------------------------------------
  // register write strobes
  // ----------------------------------------------------------------------

  // accepted writes per register; lane 0 carries every writable field
  assign ctrl_wr   = wr_access && paddr == ADDR_CTRL && pstrb[0];
  assign preset_wr = wr_access && paddr == ADDR_PRESET && pstrb[0];
  assign cmd_wr    = wr_access && paddr == ADDR_CMD && pstrb[0];
  assign wraps_wr  = wr_access && paddr == ADDR_WRAPS;     // any lanes

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------

  // parallel count enable held by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_permit <= CTRL_RESET.count_permit;
    end else if (ctrl_wr) begin
      sw_permit <= pwdata[CTRL_PERMIT_BIT];
    end
  end

  // cascade enable used while the source bit selects software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cascade <= CTRL_RESET.cascade_gate;
    end else if (ctrl_wr) begin
      sw_cascade <= pwdata[CTRL_CASCADE_BIT];
    end
  end

  // preset strobe level, low loads at every edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_preset_n <= CTRL_RESET.preset_n;
    end else if (ctrl_wr) begin
      sw_preset_n <= pwdata[CTRL_PRESET_N_BIT];
    end
  end

  // cascade source, high takes the lower stage carry pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_src <= CTRL_RESET.cascade_src;
    end else if (ctrl_wr) begin
      sw_src <= pwdata[CTRL_SRC_BIT];
    end
  end

  // control word seen by the rest of the block
  assign ctrl = '{cascade_src:  sw_src,
                  preset_n:     sw_preset_n,
                  cascade_gate: sw_cascade,
                  count_permit: sw_permit};

  // ----------------------------------------------------------------------
  // preset value register
  // ----------------------------------------------------------------------

  // parallel preset data, any value 0 to 15
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_value <= PRESET_RESET;
    end else if (preset_wr) begin
      preset_value <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // command register, one-edge pulses
  // ----------------------------------------------------------------------

  // preset pulse holds the strobe low for exactly one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_pulse <= 1'b0;
    end else begin
      preset_pulse <= cmd_wr && pwdata[CMD_PRESET_BIT];
    end
  end

  // step pulse grants the parallel permit for exactly one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_pulse <= 1'b0;
    end else begin
      step_pulse <= cmd_wr && pwdata[CMD_STEP_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // effective counter controls
  // ----------------------------------------------------------------------

  // cascade enable from the lower stage pin or from software
  assign cascade_gate = ctrl.cascade_src ? cascade_gate_in
                                         : ctrl.cascade_gate;

  // parallel enable, from the held bit or a one-edge step
  assign count_permit = ctrl.count_permit || step_pulse;

  // preset strobe, from the held level or a one-edge load
  assign preset_n     = ctrl.preset_n && !preset_pulse;

  // ----------------------------------------------------------------------
  // operation select
  // ----------------------------------------------------------------------

  // mode is a pure level decode, acted on only at the edge
  assign mode = decode_mode(preset_n, count_permit,
                            cascade_gate);

  // ----------------------------------------------------------------------
  // counter stage
  // ----------------------------------------------------------------------
  counter_stage #(
    .WIDTH              (COUNT_WIDTH)
  ) u_stage (
    .pclk               (pclk),
    .presetn            (presetn),
    .async_zero_n       (async_zero_n),
    .mode               (mode),
    .cascade_gate       (cascade_gate),
    .preset_value       (preset_value),
    .count              (count),
    .terminal_carry_out (terminal_carry_out)
  );

  // count pins straight from the stage flops
  assign count_bit0 = count[0];
  assign count_bit1 = count[1];
  assign count_bit2 = count[2];
  assign count_bit3 = count[3];

  // ----------------------------------------------------------------------
  // wrap counter
  // ----------------------------------------------------------------------

  // a roll-over edge: counting at fifteen with the clear released
  assign wrap_event = async_zero_n && mode == MODE_COUNT &&
                      at_terminal(count);

  // counts roll-overs; a write clears it, but a wrap in the same
  // cycle wins and leaves one, so a roll-over in the write cycle is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wraps <= '0;
    end else if (wrap_event) begin
      wraps <= wraps_wr ? WRAPS_W'(1) : WRAPS_W'(wraps + 1'b1);
    end else if (wraps_wr) begin
      wraps <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------------

  // live counter state, reserved bits zero
  always_comb begin
    status_word                      = 32'h0000_0000;
    status_word[STAT_COUNT_LSB +: 4] = count;
    status_word[STAT_CARRY_BIT]      = terminal_carry_out;
    status_word[STAT_ZERO_N_BIT]     = async_zero_n;
    status_word[STAT_CASCADE_BIT]    = cascade_gate;
    status_word[STAT_MODE_LSB +: 2]  = mode;
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------

  // read word selected in setup, reserved bits zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == ADDR_CTRL) begin
      next_prdata[CTRL_PERMIT_BIT]   = ctrl.count_permit;
      next_prdata[CTRL_CASCADE_BIT]  = ctrl.cascade_gate;
      next_prdata[CTRL_PRESET_N_BIT] = ctrl.preset_n;
      next_prdata[CTRL_SRC_BIT]      = ctrl.cascade_src;
    end else if (paddr == ADDR_PRESET) begin
      next_prdata[3:0] = preset_value;
    end else if (paddr == ADDR_STATUS) begin
      next_prdata = status_word;
    end else if (paddr == ADDR_CMD) begin
      next_prdata = 32'h0000_0000;                  // write-only, reads zero
    end else if (paddr == ADDR_WRAPS) begin
      next_prdata[WRAPS_W-1:0] = wraps;
    end else begin
      next_prdata = 32'h0000_0000;
    end
  end

  // read data held in a flop through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

endmodule // sync_4bit_binary_counter

/* File: tb_sync_4bit_binary_counter.sv */
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  fail_count++; $display("CHECK FAILED %0t: %h vs %h", $time, got, exp); \
  end end

module tb_sync_4bit_binary_counter;
  timeunit 1ns;
  timeprecision 1ns;
  import counter_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, async_zero_n, run;
  logic        pready, pslverr, cascade_gate_in, e, c, terminal_carry_out;
  logic        count_bit0, count_bit1, count_bit2, count_bit3;
  logic [7:0]  paddr, rnd;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb, model, p;
  logic [15:0] wraps;
  int          fail_count, checked, k;

  sync_4bit_binary_counter sync_4bit_binary_counter_inst (.*);
  lower_stage_model lower_stage_model_inst (.pclk, .run,
                                            .carry(cascade_gate_in));

  // 100 ns clock
  always #50 pclk = ~pclk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [3:0] stepped(input logic [3:0] m, input logic en);
    return en ? m + 4'h1 : m;
  endfunction

  function automatic logic [3:0] pins();
    return {count_bit3, count_bit2, count_bit1, count_bit0};
  endfunction

  // one apb transfer, result in q and e
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #(100 * 20000);
    fail_count++;
    end_of_test();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, async_zero_n, run} = 7'b0000010;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    rnd = 8'h37;
    wraps = 16'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_CTRL, 32'h0);
    `CHK(q, 32'h4)
    apb(0, ADDR_STATUS, 32'h0);
    `CHK(q, 32'h20)
    $display("done: reset values");
    // random presets and single steps, cascade on or off
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      if (i % 8 == 0) begin
        model = (i == 0) ? 4'he : rnd[7:4];
        apb(1, ADDR_PRESET, {28'h0, model});
        apb(1, ADDR_CMD, 32'h1);
        repeat (2) @(negedge pclk);
        `CHK(pins(), model)
      end
      c = rnd[0] | (i < 2);
      apb(1, ADDR_CTRL, {29'h0, 1'b1, c, 1'b0});
      apb(1, ADDR_CMD, 32'h2);
      repeat (2) @(negedge pclk);
      wraps = wraps + {15'h0, c && model == COUNT_MAX};
      model = stepped(model, c);
      `CHK(pins(), model)
      `CHK(terminal_carry_out, c && model == COUNT_MAX)
    end
    $display("done: steps");
    // held preset strobe wins over both enables
    apb(1, ADDR_PRESET, 32'h9);
    apb(1, ADDR_CTRL, 32'h3);
    repeat (2) @(negedge pclk);
    repeat (3) begin
      `CHK(pins(), 4'h9)
      @(negedge pclk);
    end
    apb(0, ADDR_STATUS, 32'h0);
    `CHK(q, 32'h269)
    apb(1, ADDR_PRESET, 32'hd);
    apb(1, ADDR_CTRL, 32'h7);
    model = 4'hd;
    @(negedge pclk);
    repeat (6) begin
      @(negedge pclk);
      model = stepped(model, 1'b1);
      `CHK(pins(), model)
    end
    wraps = wraps + 16'h1;
    $display("done: free counting");
    // clear in mid count
    @(posedge pclk);
    async_zero_n <= 1'b0;
    #1;
    `CHK({terminal_carry_out, pins()}, 5'h0)
    repeat (2) @(negedge pclk);
    `CHK(pins(), 4'h0)
    @(posedge pclk);
    async_zero_n <= 1'b1;
    apb(1, ADDR_CTRL, 32'h4);
    @(negedge pclk);
    p = pins();
    repeat (3) @(negedge pclk);
    `CHK(pins(), p)
    apb(0, ADDR_WRAPS, 32'h0);
    `CHK(q, {16'h0, wraps})
    apb(1, ADDR_WRAPS, 32'h0);
    apb(0, ADDR_WRAPS, 32'h0);
    `CHK(q, 32'h0)
    $display("done: clear and hold");
    // cascade enable taken from the lower stage's carry
    p = pins();
    apb(1, ADDR_CTRL, 32'hd);
    k = 0;
    @(posedge pclk);
    run <= 1'b1;
    repeat (40) begin
      @(posedge pclk);
      k += int'(cascade_gate_in);
    end
    run <= 1'b0;
    repeat (2) @(negedge pclk);
    `CHK(pins(), p + k[3:0])
    $display("done: cascade");
    // refused accesses
    apb(0, 8'h14, 32'h0);
    `CHK({e, q}, 33'h1_0000_0000)
    apb(1, ADDR_STATUS, 32'h0);
    `CHK(e, 1'b1)
    pstrb <= 4'he;
    apb(1, ADDR_PRESET, 32'h5);
    pstrb <= 4'hf;
    apb(0, ADDR_PRESET, 32'h0);
    `CHK(q, 32'hd)
    $display("done: errors");
    end_of_test();
  end
endmodule // tb_sync_4bit_binary_counter
